// *** design/uar_receiver.sv ***
//------------------------------------------------------------
// Purpose: Async serial receiver with voted sampling and buffer
// Assumes: sample_tick_i pulses at 16x (or 8x) the baud rate
// Notes:   Controls are plain ports on the core clock domain
//------------------------------------------------------------
// Contract
// - Complete flag set while buffer holds frames
// - Disabling receiver flushes buffer, clears flag
// - Interrupt while flag and enables set
// - Error flags travel with frame; data read advances
// - Software cannot write error flags
// - Error flags never raise interrupts
// - Frame error reflects first stop bit
// - Only first stop bit is checked
// - Overrun on full buffer, waiting char, start
// - Overrun clears on successful buffer transfer
// - Parity error only when checking enabled
// - Parity checked, odd or even, stored
// - Disable stops reception at once, frees pin
// - Sample at 16x, or 8x double speed
// - Start bit voted on samples 8-10/4-6
// - Bit timer resynchronised every start bit
// - Each bit decided by centre-sample majority
// - Voted low stop bit sets frame error
// - Next start accepted right after stop vote
// - Completed frame moved into buffer
// - Ninth bit presented with buffered frame
// - Unused upper data bits read zero
//------------------------------------------------------------
`timescale 1ns/1ps

module uar_receiver
    import uar_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Serial line and sample timing
    input wire logic rx_pin_i,
    input wire logic sample_tick_i,
    // Configuration
    input wire logic receiver_enable_bit_i,
    input wire logic double_speed_bit_i,
    input wire logic parity_enable_bit_i,
    input wire logic parity_odd_select_i,
    input wire logic [2:0] char_size_i,
    // Interrupt enables
    input wire logic rx_complete_irq_enable_i,
    input wire logic global_irq_enable_i,
    // Software data read strobe
    input wire logic data_read_i,
    // Status and data
    output logic receive_complete_flag_o,
    output logic frame_error_flag_o,
    output logic overrun_flag_o,
    output logic parity_error_flag_o,
    output logic ninth_received_bit_o,
    output logic [7:0] data_buffer_register_o,
    output logic rx_irq_o,
    output logic rx_pin_owned_o
);

    //------------------------------------------------------------
    // Declarations
    //------------------------------------------------------------
    uar_state_e state;
    logic rx_meta;
    logic rx_sync;
    logic rx_prev;
    logic [4:0] sidx;
    logic [3:0] bit_idx;
    logic [8:0] shreg;
    logic [1:0] votes;
    logic par_bit;
    logic [4:0] spb;
    logic [4:0] vfirst;
    logic [4:0] vlast;
    logic [3:0] nbits;
    logic in_window;
    logic vote_now;
    logic bit_end;
    logic voted;
    logic start_ok;
    logic frame_done;
    logic frame_fe;
    logic frame_pe;
    logic pend_valid;
    logic [8:0] pend_data;
    logic pend_fe;
    logic pend_pe;
    logic ovr_pend;
    logic buf_ready;
    logic push;
    logic flush;
    logic head_valid;
    logic [ENTRY_W-1:0] head;
    logic [ENTRY_W-1:0] entry;

    //------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------
    // Two-of-three majority
    function automatic logic majority(input logic [2:0] s);
        majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction : majority

    // Data bits for a size code
    function automatic logic [3:0] data_bits(input logic [2:0] code);
        if (code == CHAR_SIZE_NINE) begin
            data_bits = DATA_BITS_NINE;
        end else if (code[2]) begin
            data_bits = DATA_BITS_DEFAULT;
        end else begin
            data_bits = DATA_BITS_MIN + {2'b00, code[1:0]};
        end
    endfunction : data_bits

    //------------------------------------------------------------
    // Pin synchroniser
    //------------------------------------------------------------
    // Two flops before any logic sees the line
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
        end else begin
            rx_meta <= rx_pin_i;
            rx_sync <= rx_meta;
        end
    end

    //------------------------------------------------------------
    // Sample timing decode
    //------------------------------------------------------------
    // Geometry depends on speed mode
    assign spb = double_speed_bit_i ? SAMPLES_DOUBLE : SAMPLES_NORMAL;
    assign vfirst = double_speed_bit_i ? VOTE_FIRST_DOUBLE : VOTE_FIRST_NORMAL;
    assign vlast = vfirst + VOTE_SPAN;
    assign nbits = data_bits(char_size_i);
    assign in_window = sample_tick_i && (sidx >= vfirst) && (sidx <= vlast);
    assign vote_now = sample_tick_i && (sidx == vlast);
    assign bit_end = sample_tick_i && (sidx == spb);
    assign voted = majority({votes, rx_sync});
    assign start_ok = (state == UAR_START) && vote_now && !voted;

    // Stop bit decided on its last vote sample
    assign frame_done = (state == UAR_STOP) && vote_now;
    assign frame_fe = !voted;
    assign frame_pe = parity_enable_bit_i
        && ((^shreg) ^ parity_odd_select_i ^ par_bit);

    //------------------------------------------------------------
    // Vote sample shift
    //------------------------------------------------------------
    // Keeps the earlier two centre samples
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            votes <= 2'b11;
        end else if (in_window) begin
            votes <= {votes[0], rx_sync};
        end
    end

    // Last seen sample for edge search
    always_ff @(posedge core_clk_i) begin
        if (rst_i || !receiver_enable_bit_i) begin
            rx_prev <= 1'b1;
        end else if (sample_tick_i) begin
            rx_prev <= rx_sync;
        end
    end

    //------------------------------------------------------------
    // Bit timing state machine
    //------------------------------------------------------------
    // Disable aborts any frame in progress
    always_ff @(posedge core_clk_i) begin
        if (rst_i || !receiver_enable_bit_i) begin
            state <= UAR_IDLE;
            sidx <= '0;
            bit_idx <= '0;
            shreg <= DATA_RESET;
            par_bit <= 1'b0;
        end else if (sample_tick_i) begin
            sidx <= (sidx == spb) ? FIRST_LOW_SAMPLE : sidx + 5'h01;
            case (state)
                UAR_IDLE: begin
                    if (rx_prev && !rx_sync) begin
                        state <= UAR_START;
                        sidx <= FIRST_LOW_SAMPLE + 5'h01;
                        shreg <= DATA_RESET;
                    end
                end
                UAR_START: begin
                    if (vote_now && voted) begin
                        state <= UAR_IDLE;
                    end else if (bit_end) begin
                        state <= UAR_DATA;
                        bit_idx <= '0;
                    end
                end
                UAR_DATA: begin
                    if (vote_now) begin
                        shreg[bit_idx] <= voted;
                    end
                    if (bit_end) begin
                        if (bit_idx == nbits - 4'h1) begin
                            state <= parity_enable_bit_i ? UAR_PARITY : UAR_STOP;
                        end else begin
                            bit_idx <= bit_idx + 4'h1;
                        end
                    end
                end
                UAR_PARITY: begin
                    if (vote_now) begin
                        par_bit <= voted;
                    end
                    if (bit_end) begin
                        state <= UAR_STOP;
                    end
                end
                UAR_STOP: begin
                    if (vote_now) begin
                        state <= UAR_IDLE;
                    end
                end
                default: begin
                    state <= UAR_IDLE;
                end
            endcase
        end
    end

    //------------------------------------------------------------
    // Shift-register holding stage and overrun
    //------------------------------------------------------------
    // Finished frame waits here while the buffer is full
    assign push = pend_valid && buf_ready;
    assign flush = !receiver_enable_bit_i;
    assign entry = {ovr_pend, pend_pe, pend_fe, pend_data};

    always_ff @(posedge core_clk_i) begin
        if (rst_i || flush) begin
            pend_valid <= 1'b0;
            pend_data <= DATA_RESET;
            pend_fe <= 1'b0;
            pend_pe <= 1'b0;
        end else if (frame_done && (!pend_valid || push)) begin
            pend_valid <= 1'b1;
            pend_data <= shreg;
            pend_fe <= frame_fe;
            pend_pe <= frame_pe;
        end else if (push) begin
            pend_valid <= 1'b0;
        end
    end

    // Overrun: set wins over the transfer clear
    always_ff @(posedge core_clk_i) begin
        if (rst_i || flush) begin
            ovr_pend <= 1'b0;
        end else if (start_ok && pend_valid && !buf_ready) begin
            ovr_pend <= 1'b1;
        end else if (push) begin
            ovr_pend <= 1'b0;
        end
    end

    //------------------------------------------------------------
    // Receive buffer
    //------------------------------------------------------------
    uar_fifo #(
        .WIDTH(ENTRY_W),
        .DEPTH(RX_BUF_DEPTH)
    ) u_buf (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .flush_i(flush),
        .in_valid_i(pend_valid),
        .in_ready_o(buf_ready),
        .in_data_i(entry),
        .out_valid_o(head_valid),
        .out_ready_i(data_read_i),
        .out_data_o(head)
    );

    //------------------------------------------------------------
    // Software-visible status
    //------------------------------------------------------------
    // Flags come from the head entry only; no write path exists
    assign receive_complete_flag_o = head_valid;
    assign frame_error_flag_o = head_valid && head[ENT_FE_POS];
    assign overrun_flag_o = head_valid && head[ENT_DOR_POS];
    assign parity_error_flag_o = head_valid && head[ENT_PE_POS];
    assign ninth_received_bit_o = head_valid && head[8];
    assign data_buffer_register_o = head_valid ? head[7:0] : 8'h00;
    assign rx_irq_o = head_valid && rx_complete_irq_enable_i
        && global_irq_enable_i;
    assign rx_pin_owned_o = receiver_enable_bit_i;

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------
    sequence s_start_noise;
        (state == UAR_START) && vote_now && voted;
    endsequence

    sequence s_stop_vote;
        (state == UAR_STOP) && vote_now && receiver_enable_bit_i;
    endsequence

    chk_flush_on_off: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $fell(receiver_enable_bit_i) |=> !receive_complete_flag_o && !rx_irq_o)
        else $error("buffer not flushed on disable");

    chk_flag_on_push: assert property (@(posedge core_clk_i) disable iff (rst_i)
        push && receiver_enable_bit_i |=> receive_complete_flag_o)
        else $error("complete flag missing after transfer");

    chk_irq_gating: assert property (@(posedge core_clk_i) disable iff (rst_i)
        rx_irq_o |-> receive_complete_flag_o && rx_complete_irq_enable_i && global_irq_enable_i)
        else $error("interrupt without cause");

    chk_err_no_irq: assert property (@(posedge core_clk_i) disable iff (rst_i)
        frame_error_flag_o && !rx_complete_irq_enable_i |-> !rx_irq_o)
        else $error("error flag raised interrupt");

    chk_abort_idle: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !receiver_enable_bit_i |-> !rx_pin_owned_o ##1 (state == UAR_IDLE))
        else $error("reception not stopped on disable");

    chk_start_reject: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_start_noise and receiver_enable_bit_i |=> state == UAR_IDLE)
        else $error("noisy start bit accepted");

    chk_early_start: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_stop_vote |=> (state == UAR_IDLE) && (rx_prev == $past(rx_sync)))
        else $error("receiver not idle after stop vote");

    chk_overrun_set: assert property (@(posedge core_clk_i) disable iff (rst_i)
        start_ok && pend_valid && !buf_ready && receiver_enable_bit_i |=> ovr_pend)
        else $error("overrun not flagged");

    chk_overrun_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
        push && receiver_enable_bit_i |=> !ovr_pend && (entry[ENT_DOR_POS] == 1'b0))
        else $error("overrun not cleared after transfer");

    chk_parity_off: assert property (@(posedge core_clk_i) disable iff (rst_i)
        frame_done && !pend_valid && !parity_enable_bit_i |=> !pend_pe)
        else $error("parity error with checking off");

    chk_sample_wrap: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (state != UAR_IDLE) |-> (sidx <= spb) && (sidx != 5'h00))
        else $error("sample index out of range");

endmodule : uar_receiver

// *** include/uar_pkg.sv ***
//------------------------------------------------------------
// Purpose: Shared constants for the async serial receiver
// Assumes: Sample tick comes from an external baud generator
// Notes:   Counts are in sample ticks, not clock cycles
//------------------------------------------------------------
package uar_pkg;

    //------------------------------------------------------------
    // Sampling geometry
    //------------------------------------------------------------
    localparam logic [4:0] SAMPLES_NORMAL = 5'h10;  // Ticks per bit, normal speed
    localparam logic [4:0] SAMPLES_DOUBLE = 5'h08;  // Ticks per bit, double speed
    localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
    localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
    localparam logic [4:0] VOTE_SPAN = 5'h02;       // Last vote minus first vote
    localparam logic [4:0] FIRST_LOW_SAMPLE = 5'h01;

    //------------------------------------------------------------
    // Character size codes
    //------------------------------------------------------------
    localparam logic [2:0] CHAR_SIZE_NINE = 3'h7;
    localparam logic [3:0] DATA_BITS_DEFAULT = 4'h8;
    localparam logic [3:0] DATA_BITS_NINE = 4'h9;
    localparam logic [3:0] DATA_BITS_MIN = 4'h5;

    //------------------------------------------------------------
    // Receive buffer layout
    //------------------------------------------------------------
    localparam int RX_BUF_DEPTH = 2;
    localparam int DATA_W = 9;
    localparam int ENTRY_W = 12;
    localparam int ENT_FE_POS = 9;
    localparam int ENT_PE_POS = 10;
    localparam int ENT_DOR_POS = 11;
    localparam logic [8:0] DATA_RESET = 9'h000;

    //------------------------------------------------------------
    // Receiver states
    //------------------------------------------------------------
    typedef enum logic [2:0] {
        UAR_IDLE = 3'b000,
        UAR_START = 3'b001,
        UAR_DATA = 3'b010,
        UAR_PARITY = 3'b011,
        UAR_STOP = 3'b100
    } uar_state_e;

endpackage : uar_pkg

// *** design/uar_fifo.sv ***
//------------------------------------------------------------
// Purpose: Small valid/ready FIFO for received frames
// Assumes: Single clock, synchronous active-high reset
// Notes:   Flush empties it in one cycle
//------------------------------------------------------------
`timescale 1ns/1ps

module uar_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic flush_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic push;
    logic pop;

    //------------------------------------------------------------
    // Handshake
    //------------------------------------------------------------
    assign in_ready_o = (count != FULL_COUNT);
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // Pointer wrap helper
    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == LAST_PTR) ? '0 : p + PW'(1);
    endfunction : bump

    // Storage
    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // Pointers and fill level
    always_ff @(posedge core_clk_i) begin
        if (rst_i || flush_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= bump(wr_ptr);
            end
            if (pop) begin
                rd_ptr <= bump(rd_ptr);
            end
            if (push && !pop) begin
                count <= count + CW'(1);
            end else if (pop && !push) begin
                count <= count - CW'(1);
            end
        end
    end

endmodule : uar_fifo

// *** verif/uar_tx_model.sv ***
// Purpose: Remote serial transmitter driving the receive line
// Assumes: Bit time counted in sample ticks of the receiver
// Notes:   Stop bit cut short so the next start comes early
`timescale 1ns/1ps

module uar_tx_model (
    // Clock and timing
    input wire logic core_clk_i,
    input wire logic sample_tick_i,
    input wire logic double_speed_bit_i,
    // Serial line
    output logic rx_pin_o
);
    initial rx_pin_o = 1'b1;

    // Wait whole ticks, then step off the edge
    task automatic ticks(input int n);
        repeat (n) @(posedge core_clk_i iff sample_tick_i);
        @(negedge core_clk_i);
    endtask : ticks

    // Short low pulse that must be rejected
    task automatic glitch(input int n);
        rx_pin_o = 1'b0;
        ticks(n);
        rx_pin_o = 1'b1;
    endtask : glitch

    // Start, data LSB first, optional parity, one stop
    task automatic send(input logic [8:0] d, input int nb, input logic pen, input logic odd,
                        input logic bad_par, input logic bad_stop);
        int spb;
        logic par;
        @(negedge core_clk_i);
        spb = double_speed_bit_i ? 8 : 16;
        par = odd ^ bad_par;
        rx_pin_o = 1'b0;
        ticks(spb);
        for (int i = 0; i < nb; i++) begin
            rx_pin_o = d[i];
            par = par ^ d[i];
            ticks(spb);
        end
        if (pen) begin
            rx_pin_o = par;
            ticks(spb);
        end
        rx_pin_o = ~bad_stop;
        ticks(spb * 3 / 4);
        rx_pin_o = 1'b1;
    endtask : send
endmodule : uar_tx_model

// *** verif/uar_receiver_test.sv ***
// Purpose: Self-checking bench for the async serial receiver
// Assumes: Tick every fourth clock, reset held two cycles
// Notes:   Queue model predicts every buffered entry
`timescale 1ns/1ps

module uar_receiver_test;
    import uar_pkg::*;
    logic core_clk_i = 1'b0, rst_i = 1'b1, rx_pin_i, sample_tick_i = 1'b0;
    logic receiver_enable_bit_i = 1'b1, double_speed_bit_i = 1'b0;
    logic parity_enable_bit_i = 1'b0, parity_odd_select_i = 1'b0;
    logic [2:0] char_size_i = 3'h3;
    logic rx_complete_irq_enable_i = 1'b1, global_irq_enable_i = 1'b1, data_read_i = 1'b0;
    logic receive_complete_flag_o, frame_error_flag_o, overrun_flag_o, parity_error_flag_o;
    logic ninth_received_bit_o, rx_irq_o, rx_pin_owned_o;
    logic [7:0] data_buffer_register_o;
    logic [1:0] tdiv = 2'h0;
    logic [11:0] exp_q[$];
    logic [2:0] sizes[5] = '{3'h0, 3'h1, 3'h3, 3'h7, 3'h4};
    int error_cnt = 0, checks = 0, seed = 52;

    uar_receiver i_dut (.core_clk_i, .rst_i, .rx_pin_i, .sample_tick_i, .receiver_enable_bit_i,
        .double_speed_bit_i, .parity_enable_bit_i, .parity_odd_select_i, .char_size_i,
        .rx_complete_irq_enable_i, .global_irq_enable_i, .data_read_i, .receive_complete_flag_o,
        .frame_error_flag_o, .overrun_flag_o, .parity_error_flag_o, .ninth_received_bit_o,
        .data_buffer_register_o, .rx_irq_o, .rx_pin_owned_o);
    uar_tx_model i_tx (.core_clk_i, .sample_tick_i, .double_speed_bit_i, .rx_pin_o(rx_pin_i));

    //------------------------------------------------------------
    // Clock, sample tick, watchdog
    //------------------------------------------------------------
    initial begin
        forever #2.5 core_clk_i = ~core_clk_i;
    end
    always @(negedge core_clk_i) begin
        tdiv <= tdiv + 2'h1;
        sample_tick_i <= (tdiv == 2'h3);
    end
    initial begin
        #200000;
        error_cnt++;
        tally_and_finish();
    end

    //------------------------------------------------------------
    // Compare and verdict
    //------------------------------------------------------------
    task automatic cmp_bit(input string nm, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask : cmp_bit
    task automatic cmp_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_byte
    task automatic tally_and_finish();
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    //------------------------------------------------------------
    // Frame, wait and read helpers
    //------------------------------------------------------------
    task automatic frame(input logic [8:0] d, input logic bp, input logic bs);
        int nb;
        logic [8:0] m;
        nb = (char_size_i == CHAR_SIZE_NINE) ? 9 : (char_size_i > 3'h3) ? 8 : int'(char_size_i) + 5;
        m = d & ((9'h1 << nb) - 9'h1);
        exp_q.push_back({1'b0, parity_enable_bit_i & bp, bs, m});
        i_tx.send(d, nb, parity_enable_bit_i, parity_odd_select_i, bp, bs);
    endtask : frame
    task automatic wait_flag();
        int n;
        n = 0;
        while (receive_complete_flag_o !== 1'b1 && n < 2000) begin
            @(negedge core_clk_i);
            n++;
        end
    endtask : wait_flag
    task automatic read_one();
        logic [11:0] e;
        wait_flag();
        e = exp_q.pop_front();
        cmp_bit("flag", 1'b1, receive_complete_flag_o);
        cmp_bit("irq", rx_complete_irq_enable_i & global_irq_enable_i, rx_irq_o);
        cmp_bit("frame_err", e[ENT_FE_POS], frame_error_flag_o);
        cmp_bit("parity_err", e[ENT_PE_POS], parity_error_flag_o);
        cmp_bit("overrun", e[ENT_DOR_POS], overrun_flag_o);
        cmp_bit("ninth", e[8], ninth_received_bit_o);
        cmp_byte("data", e[7:0], data_buffer_register_o);
        data_read_i = 1'b1;
        @(negedge core_clk_i);
        data_read_i = 1'b0;
        @(negedge core_clk_i);
    endtask : read_one

    //------------------------------------------------------------
    // Main sequence
    //------------------------------------------------------------
    initial begin
        repeat (2) @(negedge core_clk_i);
        rst_i = 1'b0;
        cmp_bit("reset_flag", 1'b0, receive_complete_flag_o);
        cmp_bit("reset_irq", 1'b0, rx_irq_o);
        // Every speed and parity mode, several sizes, some bad bits
        for (int k = 0; k < 10; k++) begin
            char_size_i = sizes[k % 5];
            {double_speed_bit_i, parity_enable_bit_i, parity_odd_select_i} = 3'(k);
            rx_complete_irq_enable_i = (k != 4);
            frame(9'($random(seed)), k % 3 == 0, k == 4 || k == 9);
            read_one();
        end
        // Noise spike rejected, next frame intact
        {double_speed_bit_i, parity_enable_bit_i, char_size_i} = {2'h0, 3'h3};
        i_tx.glitch(3);
        i_tx.ticks(20);
        frame(9'h0A5, 1'b0, 1'b0);
        read_one();
        // Four back-to-back frames overflow the buffer
        repeat (4) frame(9'($random(seed)), 1'b0, 1'b0);
        exp_q[2] = exp_q[2] | (12'h1 << ENT_DOR_POS);
        void'(exp_q.pop_back());
        while (exp_q.size() > 0) read_one();
        cmp_bit("drained", 1'b0, receive_complete_flag_o);
        // Interrupt gating, then flush by disable
        frame(9'h05A, 1'b0, 1'b0);
        wait_flag();
        for (int m = 0; m < 4; m++) begin
            {rx_complete_irq_enable_i, global_irq_enable_i} = 2'(m);
            @(negedge core_clk_i);
            cmp_bit("irq_gate", m == 3, rx_irq_o);
        end
        receiver_enable_bit_i = 1'b0;
        @(negedge core_clk_i);
        cmp_bit("flushed", 1'b0, receive_complete_flag_o);
        cmp_bit("pin_free", 1'b0, rx_pin_owned_o);
        exp_q.delete();
        receiver_enable_bit_i = 1'b1;
        // Disable mid-frame drops it
        fork
            i_tx.send(9'h0C3, 8, 1'b0, 1'b0, 1'b0, 1'b0);
            begin
                i_tx.ticks(40);
                receiver_enable_bit_i = 1'b0;
            end
        join
        receiver_enable_bit_i = 1'b1;
        i_tx.ticks(20);
        cmp_bit("aborted", 1'b0, receive_complete_flag_o);
        frame(9'h03C, 1'b0, 1'b0);
        read_one();
        tally_and_finish();
    end
endmodule : uar_receiver_test
